// ### dv/pwc_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none

// far-side pulse source: the capture pin and the enable pin of the channel
module pwc_pulse_src (
   input  wire logic aclk,
   output logic      channel_io_pin_a,
   output logic      channel_io_pin_b
);
   initial begin
      channel_io_pin_a = 1'b0;
      channel_io_pin_b = 1'b0;
   end

   task automatic drive(input logic sel_b, input logic v);
      if (sel_b) begin
         channel_io_pin_b <= v;
      end else begin
         channel_io_pin_a <= v;
      end
   endtask : drive

   // active level for w cycles, then back to idle; idle level equals the falling-start flag
   task automatic pulse(input logic sel_b, input logic fall, input int w);
      @(posedge aclk);
      drive(sel_b, ~fall);
      repeat (w) @(posedge aclk);
      drive(sel_b, fall);
      // let the stop edge clear the synchronisers
      repeat (8) @(posedge aclk);
   endtask : pulse
endmodule : pwc_pulse_src

`default_nettype wire

// ### dv/pwc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin failures++; \
   $display("mismatch t=%0t %s got %h exp %h", $time, m, a, e); end end

module pwc_top_tb;
   import pwc_pkg::*;
   logic              aclk;
   logic              aresetn;
   logic              clk_en;
   logic [ADDR_W-1:0] awaddr;
   logic              awvalid;
   logic [31:0]       wdata;
   logic              wvalid;
   logic              bready;
   logic [ADDR_W-1:0] araddr;
   logic              arvalid;
   logic              rready;
   wire logic         awready;
   wire logic         wready;
   wire logic [1:0]   bresp;
   wire logic         bvalid;
   wire logic         arready;
   wire logic [31:0]  rdata;
   wire logic [1:0]   rresp;
   wire logic         rvalid;
   wire logic         irq;
   wire logic         pin_a;
   wire logic         pin_b;
   int                failures;
   int                comparisons;

   pwc_top #(.CNT_MAX(28'h00000ff), .CHANNEL(8'h05)) pwc_top_inst (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .channel_io_pin_a(pin_a), .channel_io_pin_b(pin_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq(irq)
   );

   pwc_pulse_src pwc_pulse_src_inst (.aclk(aclk), .channel_io_pin_a(pin_a), .channel_io_pin_b(pin_b));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp; bready <= 1'b0; break;
         end
      end
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata; r = rresp; rready <= 1'b0; break;
         end
      end
   endtask : axr

   function automatic logic [31:0] cw(input logic fall, os, pb, input logic [1:0] en, input logic [2:0] psc);
      cw = 32'h0000_0000;
      cw[CTRL_RUN] = 1'b1; cw[CTRL_FALL] = fall; cw[CTRL_ONESHOT] = os; cw[CTRL_PIN_B] = pb;
      cw[CTRL_ENLV_LO +: 2] = en; cw[CTRL_PSC_LO +: 3] = psc;
   endfunction : cw

   // stop, set the capture pin idle, clear events, start with c, send one pulse, poll the results
   task automatic measure(input logic [31:0] c, input int w, output logic [31:0] cnt, ovf, ist);
      logic [1:0] r;
      axw(REG_CTRL, 32'h0000_0000, r);
      pwc_pulse_src_inst.drive(c[CTRL_PIN_B], c[CTRL_FALL]);
      axw(REG_IRQ_STAT, 32'h0000_0003, r);
      axw(REG_CTRL, c, r);
      pwc_pulse_src_inst.pulse(c[CTRL_PIN_B], c[CTRL_FALL], w);
      axr(REG_CAPT_CNT, cnt, r);
      axr(REG_CAPT_OVF, ovf, r);
      axr(REG_IRQ_STAT, ist, r);
   endtask : measure

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axr(REG_CTRL, d, r); `CHK(d, CTRL_RESET, "ctrl reset")
      axr(REG_STATUS, d, r); `CHK(d, 32'h0000_0500, "status reset")
      axr(8'h1c, d, r); `CHK({r, d}, {RESP_SLVERR, 32'h0}, "unmapped read")
      axw(8'h1c, 32'h0000_0001, r); `CHK(r, RESP_SLVERR, "unmapped write")
      axw(REG_CAPT_CNT, 32'h0000_ffff, r); `CHK(r, RESP_OKAY, "ro write resp")
      axr(REG_CAPT_CNT, d, r); `CHK(d, 32'h0, "ro write ignored")
      $display("test regs done");
   endtask : t_regs

   task automatic t_prescale;
      logic [31:0] cnt, ovf, ist, tot, e;
      int          x;
      for (int p = 0; p < 6; p++) begin
         pwc_pulse_src_inst.drive(1'b1, 1'b0);
         measure(cw(p[0], 1'b0, 1'b0, 2'h0, 3'(p)), 2048, cnt, ovf, ist);
         x = 2048 >> (2 * p);
         tot = ovf * 256 + cnt;
         e = 32'h1;
         e[IRQ_OVF] = (x > 256);
         `CHK(tot inside {[x - 1 : x + 1]}, 1'b1, "prescaled width")
         `CHK(ist, e, "capture and wrap events")
      end
      $display("test prescale done");
   endtask : t_prescale

   task automatic t_enable;
      logic [31:0] cnt, ovf, ist;
      for (int lv = 1; lv < 3; lv++) begin
         for (int v = 0; v < 2; v++) begin
            pwc_pulse_src_inst.drive(1'b0, v[0]);
            measure(cw(1'b0, 1'b0, 1'b1, 2'(lv), 3'h0), 20, cnt, ovf, ist);
            `CHK(ist[IRQ_CAPT], (lv == 1) ? ~v[0] : v[0], "enable level gate")
         end
      end
      $display("test enable done");
   endtask : t_enable

   task automatic t_oneshot;
      logic [31:0] cnt, ovf, ist, d;
      logic [1:0]  r;
      measure(cw(1'b0, 1'b1, 1'b0, 2'h0, 3'h0), 30, cnt, ovf, ist);
      `CHK(cnt inside {[29:31]}, 1'b1, "one-shot width")
      axr(REG_STATUS, d, r); `CHK(d, 32'h0000_0504, "one-shot stopped")
      axw(REG_IRQ_STAT, 32'h0000_0003, r);
      pwc_pulse_src_inst.pulse(1'b0, 1'b0, 60);
      axr(REG_CAPT_CNT, d, r); `CHK(d, cnt, "capture kept")
      axr(REG_IRQ_STAT, d, r); `CHK(d, 32'h0, "no second capture")
      axw(REG_CTRL, cw(1'b0, 1'b1, 1'b0, 2'h0, 3'h0), r);
      axr(REG_STATUS, d, r); `CHK(d, 32'h0000_0501, "one-shot rearmed")
      axw(REG_CTRL, 32'h0, r);
      $display("test oneshot done");
   endtask : t_oneshot

   task automatic t_irq;
      logic [31:0] cnt, ovf, ist, d;
      logic [1:0]  r;
      measure(cw(1'b0, 1'b0, 1'b0, 2'h0, 3'h0), 300, cnt, ovf, ist);
      `CHK(ist, 32'h3, "both events")
      `CHK(irq, 1'b0, "masked irq")
      axw(REG_IRQ_MASK, 32'h0000_0002, r);
      axr(REG_IRQ_MASK, d, r); `CHK(d, 32'h2, "mask readback")
      `CHK(irq, 1'b1, "unmasked irq")
      axw(REG_IRQ_STAT, 32'h0000_0002, r);
      axr(REG_IRQ_STAT, d, r); `CHK(d, 32'h1, "w1c clears one bit")
      `CHK(irq, 1'b0, "irq after clear")
      axw(REG_IRQ_MASK, 32'h0, r);
      $display("test irq done");
   endtask : t_irq

   // filter on both pins, sampling every clock: a 2-cycle glitch is dropped, a long pulse is measured
   task automatic t_filter;
      logic [31:0] cnt, ovf, ist, c;
      c = cw(1'b0, 1'b0, 1'b0, 2'h0, 3'h0) | (32'h1 << CTRL_SFLT_LO) | (32'h1 << CTRL_EFLT_LO);
      measure(c, 2, cnt, ovf, ist);
      `CHK(ist[IRQ_CAPT], 1'b0, "glitch filtered out")
      measure(c, 30, cnt, ovf, ist);
      `CHK(cnt inside {[29:31]}, 1'b1, "filtered width")
      `CHK(ist[IRQ_CAPT], 1'b1, "filtered capture")
      $display("test filter done");
   endtask : t_filter

   // live count runs during a measurement and holds while the clock enable is low
   task automatic t_live;
      logic [31:0] v1, v2, d;
      logic [1:0]  r;
      axw(REG_CTRL, cw(1'b0, 1'b0, 1'b0, 2'h0, 3'h0), r);
      pwc_pulse_src_inst.drive(1'b0, 1'b1);
      repeat (10) @(posedge aclk);
      axr(REG_STATUS, d, r); `CHK(d, 32'h0000_0503, "measuring status")
      axr(REG_LIVE_CNT, v1, r);
      clk_en <= 1'b0;
      repeat (20) @(posedge aclk);
      clk_en <= 1'b1;
      axr(REG_LIVE_CNT, v2, r); `CHK(v2 - v1, 32'h3, "count frozen without clock enable")
      axw(REG_CTRL, 32'h0, r);
      pwc_pulse_src_inst.drive(1'b0, 1'b0);
      $display("test live done");
   endtask : t_live

   initial begin
      failures = 0; comparisons = 0; clk_en = 1'b1;
      aresetn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0; wvalid = 1'b0;
      bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_prescale();
      t_enable();
      t_oneshot();
      t_irq();
      t_filter();
      t_live();
      conclude();
   end

   initial begin
      repeat (40000) @(posedge aclk);
      failures++;
      $display("mismatch t=%0t watchdog expired", $time);
      conclude();
   end
endmodule : pwc_top_tb

`default_nettype wire

// ### rtl/pwc_pkg.sv
package pwc_pkg;

   // register byte offsets on the AXI4-Lite slave
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_STATUS     = 8'h04;
   localparam logic [7:0]  REG_CAPT_CNT   = 8'h08;
   localparam logic [7:0]  REG_CAPT_OVF   = 8'h0c;
   localparam logic [7:0]  REG_IRQ_STAT   = 8'h10;
   localparam logic [7:0]  REG_IRQ_MASK   = 8'h14;
   localparam logic [7:0]  REG_LIVE_CNT   = 8'h18;

   // control register fields; reset value of every register is zero except the channel field of status
   localparam int unsigned CTRL_RUN       = 0;
   localparam int unsigned CTRL_FALL      = 1;
   localparam int unsigned CTRL_ONESHOT   = 2;
   localparam int unsigned CTRL_PIN_B     = 3;
   localparam int unsigned CTRL_ENLV_LO   = 4;
   localparam int unsigned CTRL_PSC_LO    = 6;
   localparam int unsigned CTRL_SFLT_LO   = 9;
   localparam int unsigned CTRL_EFLT_LO   = 12;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK      = 32'h0000_7fff;

   // status register fields
   localparam int unsigned STAT_RUN       = 0;
   localparam int unsigned STAT_MEAS      = 1;
   localparam int unsigned STAT_DONE      = 2;
   localparam int unsigned STAT_CHAN_LO   = 8;

   // interrupt bits (status and mask share the layout)
   localparam int unsigned IRQ_CAPT       = 0;
   localparam int unsigned IRQ_OVF        = 1;
   localparam int unsigned IRQ_N          = 2;

   // counters
   localparam int unsigned CNT_W          = 28;
   localparam int unsigned OVF_W          = 16;
   localparam logic [27:0] CNT_MAX_WIDE   = 28'hfffffff;
   localparam logic [27:0] CNT_MAX_NARROW = 28'h000ffff;
   localparam int unsigned DIV_W          = 10;
   localparam int unsigned FLT_LEN        = 3;

   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [1:0] {
      PWC_EN_NONE,
      PWC_EN_LOW,
      PWC_EN_HIGH
   } pwc_enlv_t;

   typedef enum logic [1:0] {
      PWC_IDLE,
      PWC_ARMED,
      PWC_MEASURE
   } pwc_state_t;

   // decoded control fields
   typedef struct packed {
      logic       run;
      logic       fall;
      logic       oneshot;
      logic       pin_b;
      logic [1:0] enlv;
      logic [2:0] psc;
      logic [2:0] sflt;
      logic [2:0] eflt;
   } pwc_cfg_t;

   // divide select 0..5 gives /1 /4 /16 /64 /256 /1024 as a mask on a free counter
   function automatic logic [DIV_W-1:0] pwc_div_mask(input logic [2:0] sel);
      case (sel)
         3'h0:    pwc_div_mask = 10'h000;
         3'h1:    pwc_div_mask = 10'h003;
         3'h2:    pwc_div_mask = 10'h00f;
         3'h3:    pwc_div_mask = 10'h03f;
         3'h4:    pwc_div_mask = 10'h0ff;
         default: pwc_div_mask = 10'h3ff;
      endcase
   endfunction : pwc_div_mask

endpackage : pwc_pkg

// ### rtl/pwc_top.sv
// Behaviour
// - A measurement starts only on the chosen start edge of the capture pin while the enable condition holds.
// - The enable condition is none (always allowed), enable pin low, or enable pin high.
// - The enable pin is whichever channel pin is not the capture pin.
// - The counter starts at zero and wraps after its maximum, 0xFFFFFFF wide or 0xFFFF narrow.
// - A completed measurement reports channel, event type, captured count and overflow count.
// - One-shot takes one measurement and stops; periodic measures continuously.
// - The last captured count and overflow count stay readable for polling without interrupts.
// - The counter runs on the peripheral clock divided by the chosen prescaler.
// - The measurement ends and the count is captured on the edge opposite to the start edge.
// - The prescaler divides by 1, 4, 16, 64, 256 or 1024.
// - The optional noise filter samples at a divided rate and passes a level after 3 agreeing samples.
`timescale 1ns/10ps
`default_nettype none

module pwc_top
   import pwc_pkg::*;
#(
   parameter logic [CNT_W-1:0] CNT_MAX = CNT_MAX_WIDE,
   parameter logic [7:0]       CHANNEL = 8'h00
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              clk_en,
   input  wire logic              channel_io_pin_a,
   input  wire logic              channel_io_pin_b,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   irq
);

   typedef struct packed {
      logic [31:0]             ctrl;
      logic [IRQ_N-1:0]        irq_stat;
      logic [IRQ_N-1:0]        irq_mask;
      logic [1:0]              sync1;
      logic [1:0]              sync2;
      logic [1:0][FLT_LEN-1:0] hist;
      logic [1:0]              lvl;
      logic [1:0]              prev;
      logic [DIV_W-1:0]        div;
      pwc_state_t              st;
      logic                    done;
      logic [CNT_W-1:0]        cnt;
      logic [OVF_W-1:0]        ovf;
      logic [CNT_W-1:0]        cap;
      logic [OVF_W-1:0]        cap_ovf;
      logic                    aw_hold;
      logic [ADDR_W-1:0]       awaddr;
      logic                    w_hold;
      logic [31:0]             wdata;
      logic [3:0]              wstrb;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [1:0]              rresp;
      logic [31:0]             rdata;
      logic                    irq;
   } pwc_regs_t;

   pwc_regs_t        r_q;
   pwc_regs_t        r_d;
   pwc_cfg_t         cfg;
   logic [1:0]       pin_in;
   logic             cap_idx;
   logic             cap_lvl;
   logic             cap_prev;
   logic             en_lvl;
   logic             en_ok;
   logic             rise;
   logic             fall;
   logic             start_hit;
   logic             stop_hit;
   logic             tick;
   logic [DIV_W-1:0] psc_mask;
   logic [IRQ_N-1:0] irq_set;
   logic [IRQ_N-1:0] irq_clr;

   function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  ws);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (ws[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      apply_strb = res;
   endfunction : apply_strb

   assign cfg.run     = r_q.ctrl[CTRL_RUN];
   assign cfg.fall    = r_q.ctrl[CTRL_FALL];
   assign cfg.oneshot = r_q.ctrl[CTRL_ONESHOT];
   assign cfg.pin_b   = r_q.ctrl[CTRL_PIN_B];
   assign cfg.enlv    = r_q.ctrl[CTRL_ENLV_LO +: 2];
   assign cfg.psc     = r_q.ctrl[CTRL_PSC_LO +: 3];
   assign cfg.sflt    = r_q.ctrl[CTRL_SFLT_LO +: 3];
   assign cfg.eflt    = r_q.ctrl[CTRL_EFLT_LO +: 3];

   assign pin_in      = {channel_io_pin_b, channel_io_pin_a};

   // capture pin is the selected one, enable pin is the other one
   assign cap_idx     = cfg.pin_b;
   assign cap_lvl     = r_q.lvl[cap_idx];
   assign cap_prev    = r_q.prev[cap_idx];
   assign en_lvl      = r_q.lvl[~cap_idx];
   assign rise        = cap_lvl & ~cap_prev;
   assign fall        = ~cap_lvl & cap_prev;

   always_comb begin
      case (cfg.enlv)
         PWC_EN_LOW:  en_ok = ~en_lvl;
         PWC_EN_HIGH: en_ok = en_lvl;
         default:     en_ok = 1'b1;
      endcase
   end

   assign start_hit   = (r_q.st == PWC_ARMED) && (cfg.fall ? fall : rise) && en_ok;
   assign stop_hit    = (r_q.st == PWC_MEASURE) && (cfg.fall ? rise : fall);
   assign psc_mask    = pwc_div_mask(cfg.psc);
   assign tick        = (r_q.div & psc_mask) == psc_mask;

   always_comb begin
      logic [2:0]       fsel;
      logic [DIV_W-1:0] fmask;
      logic             wr_ok;
      r_d   = r_q;
      fsel  = 3'h0;
      fmask = '0;
      wr_ok = 1'b0;

      r_d.div = r_q.div + 1'b1;

      // two-stage synchroniser then optional 3-sample filter per pin
      for (int i = 0; i < 2; i++) begin
         r_d.sync1[i] = pin_in[i];
         r_d.sync2[i] = r_q.sync1[i];
         fsel         = (cfg.pin_b == 1'(i)) ? cfg.sflt : cfg.eflt;
         fmask        = pwc_div_mask(fsel - 3'h1);
         if (fsel == 3'h0) begin
            r_d.lvl[i] = r_q.sync2[i];
         end else if ((r_q.div & fmask) == fmask) begin
            r_d.hist[i] = {r_q.hist[i][FLT_LEN-2:0], r_q.sync2[i]};
            if (r_d.hist[i] == {FLT_LEN{1'b1}}) begin
               r_d.lvl[i] = 1'b1;
            end else if (r_d.hist[i] == {FLT_LEN{1'b0}}) begin
               r_d.lvl[i] = 1'b0;
            end
         end
      end
      r_d.prev = r_q.lvl;

      // measurement sequencer
      irq_set = '0;
      case (r_q.st)
         PWC_IDLE: begin
            if (cfg.run && !r_q.done) begin
               r_d.st = PWC_ARMED;
            end
         end
         PWC_ARMED: begin
            if (start_hit) begin
               r_d.st  = PWC_MEASURE;
               r_d.cnt = '0;
               r_d.ovf = '0;
            end
         end
         PWC_MEASURE: begin
            if (stop_hit) begin
               r_d.cap           = r_q.cnt;
               r_d.cap_ovf       = r_q.ovf;
               irq_set[IRQ_CAPT] = 1'b1;
               if (cfg.oneshot) begin
                  r_d.st   = PWC_IDLE;
                  r_d.done = 1'b1;
               end else begin
                  r_d.st = PWC_ARMED;
               end
            end else if (tick) begin
               if (r_q.cnt == CNT_MAX) begin
                  r_d.cnt          = '0;
                  r_d.ovf          = r_q.ovf + 1'b1;
                  irq_set[IRQ_OVF] = 1'b1;
               end else begin
                  r_d.cnt = r_q.cnt + 1'b1;
               end
            end
         end
         default: begin
            r_d.st = PWC_IDLE;
         end
      endcase
      // clearing run stops and clears the timer; captured values remain
      if (!cfg.run) begin
         r_d.st  = PWC_IDLE;
         r_d.cnt = '0;
         r_d.ovf = '0;
      end

      // write channel: address and data in either order
      if (r_q.bvalid && s_axi_bready) begin
         r_d.bvalid = 1'b0;
      end
      if (r_q.awready && s_axi_awvalid) begin
         r_d.aw_hold = 1'b1;
         r_d.awaddr  = s_axi_awaddr;
      end
      if (r_q.wready && s_axi_wvalid) begin
         r_d.w_hold = 1'b1;
         r_d.wdata  = s_axi_wdata;
         r_d.wstrb  = s_axi_wstrb;
      end
      irq_clr = '0;
      if (r_d.aw_hold && r_d.w_hold && !r_d.bvalid) begin
         wr_ok = 1'b1;
         case (r_d.awaddr)
            REG_CTRL: begin
               r_d.ctrl = apply_strb(r_q.ctrl, r_d.wdata, r_d.wstrb) & CTRL_MASK;
               if (r_d.wstrb[0] && r_d.wdata[CTRL_RUN]) begin
                  r_d.done = r_d.done & ~r_q.done;                         // an end of measurement now wins
               end
            end
            REG_IRQ_STAT: begin
               if (r_d.wstrb[0]) begin
                  irq_clr = r_d.wdata[IRQ_N-1:0];
               end
            end
            REG_IRQ_MASK: begin
               if (r_d.wstrb[0]) begin
                  r_d.irq_mask = r_d.wdata[IRQ_N-1:0];
               end
            end
            REG_STATUS, REG_CAPT_CNT, REG_CAPT_OVF, REG_LIVE_CNT: begin
               wr_ok = 1'b1;
            end
            default: begin
               wr_ok = 1'b0;
            end
         endcase
         r_d.aw_hold = 1'b0;
         r_d.w_hold  = 1'b0;
         r_d.bvalid  = 1'b1;
         r_d.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      // a new event wins over a clear in the same cycle
      r_d.irq_stat = (r_q.irq_stat & ~irq_clr) | irq_set;

      // read channel
      if (r_q.rvalid && s_axi_rready) begin
         r_d.rvalid = 1'b0;
      end
      if (r_q.arready && s_axi_arvalid) begin
         r_d.rvalid = 1'b1;
         r_d.rresp  = RESP_OKAY;
         r_d.rdata  = '0;
         case (s_axi_araddr)
            REG_CTRL: begin
               r_d.rdata = r_q.ctrl;
            end
            REG_STATUS: begin
               r_d.rdata[STAT_RUN]        = r_q.st != PWC_IDLE;
               r_d.rdata[STAT_MEAS]       = r_q.st == PWC_MEASURE;
               r_d.rdata[STAT_DONE]       = r_q.done;
               r_d.rdata[STAT_CHAN_LO +: 8] = CHANNEL;
            end
            REG_CAPT_CNT: begin
               r_d.rdata[CNT_W-1:0] = r_q.cap;
            end
            REG_CAPT_OVF: begin
               r_d.rdata[OVF_W-1:0] = r_q.cap_ovf;
            end
            REG_IRQ_STAT: begin
               r_d.rdata[IRQ_N-1:0] = r_q.irq_stat;
            end
            REG_IRQ_MASK: begin
               r_d.rdata[IRQ_N-1:0] = r_q.irq_mask;
            end
            REG_LIVE_CNT: begin
               r_d.rdata[CNT_W-1:0] = r_q.cnt;
            end
            default: begin
               r_d.rresp = RESP_SLVERR;
            end
         endcase
      end

      r_d.awready = ~r_d.aw_hold & ~r_d.bvalid;
      r_d.wready  = ~r_d.w_hold & ~r_d.bvalid;
      r_d.arready = ~r_d.rvalid;
      r_d.irq     = |(r_d.irq_stat & r_d.irq_mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_q <= '0;
      end else if (clk_en) begin
         r_q <= r_d;
      end
   end

   assign s_axi_awready = r_q.awready;
   assign s_axi_wready  = r_q.wready;
   assign s_axi_bvalid  = r_q.bvalid;
   assign s_axi_bresp   = r_q.bresp;
   assign s_axi_arready = r_q.arready;
   assign s_axi_rvalid  = r_q.rvalid;
   assign s_axi_rresp   = r_q.rresp;
   assign s_axi_rdata   = r_q.rdata;
   assign irq           = r_q.irq;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_stop;
      clk_en && stop_hit;
   endsequence

   sequence s_wrap;
      clk_en && (r_q.st == PWC_MEASURE) && !stop_hit && tick && (r_q.cnt == CNT_MAX) && cfg.run;
   endsequence

   chk_start_edge: assert property (
      clk_en && cfg.run && (r_q.st == PWC_ARMED) |=> (r_q.st == PWC_MEASURE) == $past(start_hit))
      else $error("measurement start does not follow the start edge");

   chk_enable_gate: assert property (
      clk_en && (r_q.st == PWC_ARMED) && (cfg.enlv == PWC_EN_LOW) && en_lvl |=> r_q.st != PWC_MEASURE)
      else $error("measurement started while enable pin was high");

   chk_wrap_count: assert property (
      s_wrap |=> (r_q.cnt == '0) && (r_q.ovf == $past(r_q.ovf) + 1'b1) && r_q.irq_stat[IRQ_OVF])
      else $error("counter wrap did not bump overflow count");

   chk_capture_report: assert property (
      s_stop |=> (r_q.cap == $past(r_q.cnt)) && (r_q.cap_ovf == $past(r_q.ovf)) && r_q.irq_stat[IRQ_CAPT])
      else $error("captured values do not match the counter at the stop edge");

   chk_oneshot_stop: assert property (
      (s_stop and cfg.oneshot) ##1 (!clk_en || !(r_q.ctrl[CTRL_RUN] && !r_q.done)) [*2] |-> r_q.st == PWC_IDLE)
      else $error("one-shot mode did not stop after one measurement");

   chk_capture_hold: assert property (
      !stop_hit |=> $stable(r_q.cap) && $stable(r_q.cap_ovf))
      else $error("captured values changed without a stop edge");

   chk_prescale_hold: assert property (
      (r_q.st == PWC_MEASURE) && !tick && !stop_hit && cfg.run |=> $stable(r_q.cnt))
      else $error("counter advanced without a prescaler tick");

   chk_filter_agree: assert property (
      (cfg.sflt != 3'h0) && (cfg.eflt != 3'h0) && $stable(r_q.ctrl) ##1 $changed(r_q.lvl[0])
      |-> r_q.hist[0] == {FLT_LEN{r_q.lvl[0]}})
      else $error("filtered level changed without three agreeing samples");

endmodule : pwc_top

`default_nettype wire
